// File: hdl/elg_event_log.sv
// event log ring buffer with apb register access
`timescale 1ns/1ps
module elg_event_log
  import elg_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // event source, same clock
  input  wire logic        ev_valid,
  input  wire elg_event_t  ev_data,
  input  wire logic        clock_synced,
  // display side
  output logic             popup_show
);

  // ==========================================================================
  // state
  elg_entry_t       store_q [STORE_N];
  elg_ctrl_t        ctrl_q;
  logic [PTR_W-1:0] depth_q, count_q, unread_q, wr_q, rd_q, disp_q;
  logic [PTR_W-1:0] count_d, unread_d, wr_d, rd_d, disp_d;
  logic [MASK_N-1:0] mask_q;
  elg_entry_t       last_q;
  logic             last_valid_q, pop_ok_q, popup_q;
  logic [31:0]      rdata_q, rdata_d;

  // ==========================================================================
  // ring arithmetic
  function automatic logic [PTR_W-1:0] ring_add(input logic [PTR_W-1:0] a,
                                                input logic [PTR_W-1:0] b,
                                                input logic [PTR_W-1:0] d);
    logic [PTR_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, d}) begin
      s = s - {1'b0, d};
    end
    return s[PTR_W-1:0];
  endfunction

  function automatic logic [PTR_W-1:0] ring_sub(input logic [PTR_W-1:0] a,
                                                input logic [PTR_W-1:0] b,
                                                input logic [PTR_W-1:0] d);
    if (a >= b) begin
      return a - b;
    end
    return a + d - b;  // true result is below d, so wrap of the sum is harmless
  endfunction

  function automatic logic [31:0] entry_word(input elg_entry_t e, input logic v,
                                             input logic [1:0] sel);
    elg_word0_t w0;
    w0 = '{valid: v, overflow_tag: e.overflow_tag, unsync: e.unsync,
           fault_value_scaling: e.fault_value_scaling,
           show_channel: (e.event_channel != '0),
           event_channel: e.event_channel, event_number: e.event_number,
           fault: e.fault};
    case (sel)
      2'h0:    return w0;
      2'h1:    return {16'h0000, e.date};
      default: return {5'h00, e.tod};
    endcase
  endfunction

  // ==========================================================================
  // bus decode
  logic setup, acc_wr, acc_rd, mapped;
  assign setup  = ce && psel && !penable;
  assign acc_wr = ce && psel && penable && pwrite;
  assign acc_rd = ce && psel && penable && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_UNREAD);
  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_q;

  // depth write, clamped into the legal range
  logic [PTR_W-1:0] depth_wr;
  logic             depth_chg, clr_now;
  always_comb begin
    depth_wr = pwdata[PTR_W-1:0];
    if (pwdata[31:PTR_W] != '0 || depth_wr > DEPTH_MAX) begin
      depth_wr = DEPTH_MAX;
    end else if (depth_wr < DEPTH_MIN) begin
      depth_wr = DEPTH_MIN;
    end
  end
  assign depth_chg = acc_wr && paddr == OFS_DEPTH && depth_wr != depth_q;
  assign clr_now   = depth_chg || (acc_wr && paddr == OFS_CTRL && pwdata[CLR_BIT]);

  // ==========================================================================
  // event intake and remote pop
  logic       push, pop, full;
  elg_entry_t new_e;
  assign push = ce && ev_valid && !mask_q[ev_data.event_number] && !clr_now;
  assign pop  = acc_rd && paddr == OFS_POP && pop_ok_q && !clr_now;
  assign full = (count_q == depth_q);

  // code with date and time stamp
  always_comb begin
    new_e.event_channel       = ev_data.event_channel;
    new_e.event_number        = ev_data.event_number;
    new_e.date                = ev_data.date;
    new_e.tod                 = ev_data.tod;
    new_e.fault_value_scaling = ctrl_q.per_unit_scale;
    new_e.fault = ctrl_q.per_unit_scale ? ev_data.fault_pu : ev_data.fault_pri;
    new_e.unsync              = ctrl_q.sync_mark && !clock_synced;
    new_e.overflow_tag        = full;
  end

  // storage, no reset needed: the pointers say what is valid
  always_ff @(posedge pclk) begin
    if (push) begin
      store_q[wr_q] <= new_e;
    end
  end

  // pointer next state
  logic [PTR_W-1:0] u_mid, rd_mid;
  always_comb begin
    wr_d     = wr_q;
    count_d  = count_q;
    u_mid    = pop ? unread_q - 11'd1 : unread_q;
    rd_mid   = pop ? ring_add(rd_q, 11'd1, depth_q) : rd_q;
    rd_d     = rd_mid;
    unread_d = u_mid;
    if (push) begin
      wr_d = ring_add(wr_q, 11'd1, depth_q);
      if (!full) begin
        count_d = count_q + 11'd1;
      end
      // an unread entry lost to overwrite drags the read pointer along
      if (u_mid == depth_q) begin
        rd_d = ring_add(rd_mid, 11'd1, depth_q);
      end else begin
        unread_d = u_mid + 11'd1;
      end
    end
    if (clr_now) begin
      wr_d     = '0;
      count_d  = '0;
      rd_d     = '0;
      unread_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q     <= '0;
      count_q  <= '0;
      rd_q     <= '0;
      unread_q <= '0;
    end else if (ce) begin
      wr_q     <= wr_d;
      count_q  <= count_d;
      rd_q     <= rd_d;
      unread_q <= unread_d;
    end
  end

  // ==========================================================================
  // settings registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= '0;
      depth_q <= DEPTH_DEF;
      mask_q  <= '0;
    end else if (acc_wr) begin
      case (paddr)
        OFS_CTRL:    ctrl_q    <= {27'h0, 1'b0, pwdata[3:0]};
        OFS_DEPTH:   depth_q   <= depth_wr;  // clamp keeps 50 to 2000
        OFS_MASK_LO: mask_q[31:0]  <= pwdata;
        OFS_MASK_HI: mask_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // popup pending: a new event in the status clearing cycle still wins, a log clear drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      popup_q <= 1'b0;
    end else if (ce) begin
      if (push && ctrl_q.popup_en) begin
        popup_q <= 1'b1;
      end else if (!ctrl_q.popup_en || clr_now ||
                   (acc_wr && paddr == OFS_STATUS && pwdata[POPUP_BIT])) begin
        popup_q <= 1'b0;
      end
    end
  end
  assign popup_show = popup_q;

  // ==========================================================================
  // local display browsing
  logic [PTR_W-1:0] newest, oldest, disp_idx;
  assign newest = ring_sub(wr_q, 11'd1, depth_q);
  assign oldest = ring_sub(wr_q, count_q, depth_q);
  assign disp_idx = ctrl_q.new_old ? ring_sub(newest, disp_q, depth_q)
                                   : ring_add(oldest, disp_q, depth_q);

  always_comb begin
    disp_d = disp_q;
    if (acc_wr && paddr == OFS_DISP_CMD) begin
      if (pwdata[DISP_FWD_BIT] && (disp_q + 11'd1) < count_q) begin
        disp_d = disp_q + 11'd1;
      end else if (pwdata[DISP_BWD_BIT] && disp_q != '0) begin
        disp_d = disp_q - 11'd1;
      end
    end
    if (clr_now) begin
      disp_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_q <= '0;
    end else if (ce) begin
      disp_q <= disp_d;
    end
  end

  // ==========================================================================
  // read path: data captured in the setup cycle, pop commits in access
  logic have_disp;
  assign have_disp = (count_q != '0);
  always_comb begin
    case (paddr)
      OFS_CTRL:     rdata_d = ctrl_q;
      OFS_DEPTH:    rdata_d = {21'h0, depth_q};
      OFS_COUNT:    rdata_d = {21'h0, count_q};
      OFS_MASK_LO:  rdata_d = mask_q[31:0];
      OFS_MASK_HI:  rdata_d = mask_q[63:32];
      OFS_POP:      rdata_d = entry_word(store_q[rd_q], unread_q != '0, 2'h0);
      OFS_LAST_W0:  rdata_d = entry_word(last_q, last_valid_q, 2'h0);
      OFS_LAST_W1:  rdata_d = entry_word(last_q, last_valid_q, 2'h1);
      OFS_LAST_W2:  rdata_d = entry_word(last_q, last_valid_q, 2'h2);
      OFS_DISP_CMD: rdata_d = {21'h0, disp_q};
      OFS_DISP_W0:  rdata_d = entry_word(store_q[disp_idx], have_disp, 2'h0);
      OFS_DISP_W1:  rdata_d = entry_word(store_q[disp_idx], have_disp, 2'h1);
      OFS_DISP_W2:  rdata_d = entry_word(store_q[disp_idx], have_disp, 2'h2);
      OFS_STATUS:   rdata_d = {30'h0, full, popup_q};
      OFS_UNREAD:   rdata_d = {21'h0, unread_q};
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q      <= '0;
      pop_ok_q     <= 1'b0;
      last_q       <= '0;
      last_valid_q <= 1'b0;
    end else if (setup) begin
      rdata_q  <= rdata_d;
      pop_ok_q <= !pwrite && paddr == OFS_POP && unread_q != '0;
      if (!pwrite && paddr == OFS_POP && unread_q != '0) begin
        last_q       <= store_q[rd_q];
        last_valid_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mask_blocks: assert property (
    (ce && ev_valid && mask_q[ev_data.event_number] && !clr_now) |=> $stable(count_q)
    && $stable(wr_q)) else $error("masked event was stored");
  chk_depth_range: assert property (
    depth_q >= DEPTH_MIN && depth_q <= DEPTH_MAX && count_q <= depth_q)
    else $error("depth or count out of range");
  chk_depth_clears: assert property (
    depth_chg |=> count_q == '0 && unread_q == '0 && wr_q == '0)
    else $error("depth change kept entries");
  chk_clear_empty: assert property (
    clr_now |=> count_q == '0 && rd_q == '0) else $error("clear left entries");
  chk_pop_advance: assert property (
    (pop && !push) |=> rd_q == ring_add($past(rd_q), 11'd1, depth_q)
    && unread_q == $past(unread_q) - 11'd1) else $error("pop did not advance");
  chk_reread_stable: assert property (
    (acc_rd && paddr == OFS_LAST_W0 && !push && !clr_now) |=> $stable(rd_q)
    && $stable(last_q)) else $error("re-read moved pointer");
  chk_browse_indep: assert property (
    (acc_wr && paddr == OFS_DISP_CMD && !push) |=> $stable(rd_q) && $stable(unread_q))
    else $error("browse moved remote pointer");
  chk_overflow_tag: assert property (
    (push && full) |=> store_q[$past(wr_q)].overflow_tag && count_q == depth_q)
    else $error("overwrite lacks overflow tag");
  chk_unsync_flag: assert property (
    (push && ctrl_q.sync_mark && !clock_synced) |=> store_q[$past(wr_q)].unsync)
    else $error("unsynchronised stamp not flagged");
  chk_popup_gate: assert property (
    (ce && !ctrl_q.popup_en) |=> !popup_q) else $error("popup shown while disabled");

  cov_overwrite:  cover property (push && full);
  cov_pop_push:   cover property (pop && push);
  cov_reread:     cover property (pop ##[1:20] (acc_rd && paddr == OFS_LAST_W0));
  cov_browse_new: cover property (ctrl_q.new_old && disp_q != '0);

endmodule

// File: hdl/elg_pkg.sv
// constants, field layouts and carrier types of the event log ring buffer
package elg_pkg;

  // ==========================================================================
  // sizes
  localparam int             PTR_W     = 11;
  localparam int             NUM_W     = 6;
  localparam int             CH_W      = 5;
  localparam int             MASK_N    = 64;
  localparam logic [PTR_W-1:0] DEPTH_MIN = 11'd50;
  localparam logic [PTR_W-1:0] DEPTH_MAX = 11'd2000;
  localparam logic [PTR_W-1:0] DEPTH_DEF = 11'd200;
  localparam int             STORE_N   = 2000;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DEPTH    = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_MASK_LO  = 8'h0c;
  localparam logic [7:0] OFS_MASK_HI  = 8'h10;
  localparam logic [7:0] OFS_POP      = 8'h14;
  localparam logic [7:0] OFS_LAST_W0  = 8'h18;
  localparam logic [7:0] OFS_LAST_W1  = 8'h1c;
  localparam logic [7:0] OFS_LAST_W2  = 8'h20;
  localparam logic [7:0] OFS_DISP_CMD = 8'h24;
  localparam logic [7:0] OFS_DISP_W0  = 8'h28;
  localparam logic [7:0] OFS_DISP_W1  = 8'h2c;
  localparam logic [7:0] OFS_DISP_W2  = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h34;
  localparam logic [7:0] OFS_UNREAD   = 8'h38;

  // ==========================================================================
  // field layouts
  typedef struct packed {
    logic [26:0] rsv;
    logic        clear_log_cmd;      // self clearing
    logic        sync_mark;          // flag unsynchronised stamps
    logic        popup_en;
    logic        per_unit_scale;     // 1 per unit, 0 primary
    logic        new_old;            // 1 newest first on display
  } elg_ctrl_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } elg_date_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
    logic [9:0] msec;
  } elg_time_t;

  typedef struct packed {
    logic [CH_W-1:0]  event_channel;
    logic [NUM_W-1:0] event_number;
    logic [15:0]      fault_pu;
    logic [15:0]      fault_pri;
    elg_date_t        date;
    elg_time_t        tod;
  } elg_event_t;

  typedef struct packed {
    logic             overflow_tag;
    logic             unsync;
    logic             fault_value_scaling;
    logic [CH_W-1:0]  event_channel;
    logic [NUM_W-1:0] event_number;
    logic [15:0]      fault;
    elg_date_t        date;
    elg_time_t        tod;
  } elg_entry_t;

  typedef struct packed {
    logic             valid;
    logic             overflow_tag;
    logic             unsync;
    logic             fault_value_scaling;
    logic             show_channel;
    logic [CH_W-1:0]  event_channel;
    logic [NUM_W-1:0] event_number;
    logic [15:0]      fault;
  } elg_word0_t;

  localparam int DISP_FWD_BIT = 0;
  localparam int DISP_BWD_BIT = 1;
  localparam int POPUP_BIT    = 0;
  localparam int CLR_BIT      = 4;

endpackage

// File: dv/elg_remote_master.sv
// remote supervisory master model speaking apb to the event log
`timescale 1ns/1ps
module elg_remote_master (
  // clock
  input  wire logic        pclk,
  // apb request side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer side
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ==========================================================================
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // ==========================================================================
  // one apb transfer, request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed, the bench timeout ends a hang
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: dv/elg_event_log_tb.sv
// self-checking testbench of the event log ring buffer
`timescale 1ns/1ps
module elg_event_log_tb;
  import elg_pkg::*;
  // ==========================================================================
  // signals
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ev_valid;
  elg_event_t  ev_data;
  logic        clock_synced;
  logic        popup_show;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  elg_event_log elg_event_log_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ev_valid(ev_valid), .ev_data(ev_data),
    .clock_synced(clock_synced), .popup_show(popup_show));

  elg_remote_master elg_remote_master_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ==========================================================================
  // clock and hang guard, ceiling well above the few hundred cycles used
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ==========================================================================
  // helpers
  function automatic elg_event_t mk(logic [4:0] ch, logic [5:0] num, logic [15:0] f);
    return '{event_channel: ch, event_number: num, fault_pu: f + 16'h0100, fault_pri: f,
             date: '{year: 7'h07, month: 4'h1, day: 5'h1f},
             tod: '{hour: 5'h08, minute: 6'h23, second: 6'h0d, msec: 10'h19d}};
  endfunction
  // expected word0 of a valid entry
  function automatic logic [31:0] w0(logic ovf, logic uns, logic sc, logic [4:0] ch,
                                     logic [5:0] num, logic [15:0] f);
    return {1'b1, ovf, uns, sc, (ch != 5'h00), ch, num, f};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    elg_remote_master_inst.xfer(1'b1, a, d, rdat, rerr);
  endtask
  task automatic rd(input logic [7:0] a);
    elg_remote_master_inst.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask
  task automatic ev(input logic [4:0] ch, input logic [5:0] num, input logic [15:0] f);
    @(posedge pclk);
    ev_valid <= 1'b1;
    ev_data  <= mk(ch, num, f);
    @(posedge pclk);
    ev_valid <= 1'b0;
  endtask
  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk_w(n, e, rdat);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    presetn      = 1'b0;
    ce           = 1'b1;
    ev_valid     = 1'b0;
    ev_data      = '0;
    clock_synced = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_DEPTH, 32'h0000_00c8, "depth_reset");
    rchk(OFS_CTRL, 32'h0000_0000, "ctrl_reset");
    rd(OFS_POP);
    chk_b("pop_empty_valid", 1'b0, rdat[31]);
    // one event, popped then re-read through the last-entry window
    ev(5'h01, 6'h02, 16'h001b);
    rchk(OFS_COUNT, 32'h0000_0001, "count_one");
    rchk(OFS_POP, w0(0, 0, 0, 5'h01, 6'h02, 16'h001b), "pop_w0");
    rchk(OFS_UNREAD, 32'h0000_0000, "unread_after_pop");
    rchk(OFS_LAST_W1, {16'h0000, 7'h07, 4'h1, 5'h1f}, "last_date");
    rchk(OFS_LAST_W2, {5'h00, 5'h08, 6'h23, 6'h0d, 10'h19d}, "last_time");
    repeat (2) rchk(OFS_LAST_W0, w0(0, 0, 0, 5'h01, 6'h02, 16'h001b), "last_w0");
    rchk(OFS_UNREAD, 32'h0000_0000, "unread_after_reread");
    // channel zero, per-unit value, unsynchronised stamp with marking on
    wr(OFS_CTRL, 32'h0000_000a);
    clock_synced <= 1'b0;
    ev(5'h00, 6'h03, 16'h0005);
    clock_synced <= 1'b1;
    rchk(OFS_POP, w0(0, 1, 1, 5'h00, 6'h03, 16'h0105), "pop_pu_unsync");
    // masked numbers in both halves are dropped, an unmasked one is kept
    wr(OFS_MASK_LO, 32'h0000_0010);
    wr(OFS_MASK_HI, 32'h0000_0100);
    ev(5'h01, 6'h04, 16'h0000);
    ev(5'h01, 6'h28, 16'h0000);
    rchk(OFS_COUNT, 32'h0000_0002, "count_masked");
    wr(OFS_MASK_LO, 32'h0000_0000);
    wr(OFS_MASK_HI, 32'h0000_0000);
    ev(5'h01, 6'h04, 16'h0000);
    rchk(OFS_COUNT, 32'h0000_0003, "count_unmasked");
    // popup raised, cleared, then suppressed
    wr(OFS_CTRL, 32'h0000_0004);
    ev(5'h01, 6'h06, 16'h0000);
    // look half a cycle later, once the flag launched at that edge has settled
    @(negedge pclk);
    chk_b("popup_on", 1'b1, popup_show);
    wr(OFS_STATUS, 32'h0000_0001);
    @(negedge pclk);
    chk_b("popup_cleared", 1'b0, popup_show);
    wr(OFS_CTRL, 32'h0000_0000);
    ev(5'h01, 6'h07, 16'h0000);
    @(negedge pclk);
    chk_b("popup_off", 1'b0, popup_show);
    // clear command empties count and unread
    wr(OFS_CTRL, 32'h0000_0010);
    rchk(OFS_COUNT, 32'h0000_0000, "count_clear");
    rchk(OFS_UNREAD, 32'h0000_0000, "unread_clear");
    rchk(OFS_CTRL, 32'h0000_0000, "clear_self");
    // depth clamps at both ends and a change discards entries
    ev(5'h01, 6'h08, 16'h0000);
    wr(OFS_DEPTH, 32'h0000_000a);
    rchk(OFS_DEPTH, 32'h0000_0032, "depth_low");
    rchk(OFS_COUNT, 32'h0000_0000, "count_depth_change");
    wr(OFS_DEPTH, 32'h0000_0bb8);
    rchk(OFS_DEPTH, 32'h0000_07d0, "depth_high");
    wr(OFS_DEPTH, 32'h0000_0032);
    // back-to-back burst one past a depth of 50
    for (int i = 0; i < 51; i++) begin
      @(posedge pclk);
      ev_valid <= 1'b1;
      ev_data  <= mk(5'h01, i[5:0], i[15:0]);
    end
    @(posedge pclk);
    ev_valid <= 1'b0;
    rchk(OFS_COUNT, 32'h0000_0032, "count_full");
    rd(OFS_STATUS);
    chk_b("status_full", 1'b1, rdat[1]);
    rchk(OFS_POP, w0(0, 0, 0, 5'h01, 6'h01, 16'h0001), "pop_oldest_left");
    // display browsing apart from the remote pointer, both orders
    wr(OFS_DISP_CMD, 32'h0000_0001);
    rchk(OFS_DISP_CMD, 32'h0000_0001, "disp_pos");
    rchk(OFS_DISP_W0, w0(0, 0, 0, 5'h01, 6'h02, 16'h0002), "disp_old_new");
    rchk(OFS_UNREAD, 32'h0000_0031, "unread_kept");
    wr(OFS_CTRL, 32'h0000_0001);
    rchk(OFS_DISP_W0, w0(0, 0, 0, 5'h01, 6'h31, 16'h0031), "disp_new_old");
    wr(OFS_DISP_CMD, 32'h0000_0002);
    rchk(OFS_DISP_W0, w0(1, 0, 0, 5'h01, 6'h32, 16'h0032), "disp_newest_ovf");
    // clock enable low: an event is ignored and pready stays low
    ce <= 1'b0;
    ev(5'h01, 6'h09, 16'h0000);
    @(negedge pclk);
    chk_b("pready_frozen", 1'b0, pready);
    @(posedge pclk);
    ce <= 1'b1;
    rchk(OFS_UNREAD, 32'h0000_0031, "unread_frozen");
    // unmapped and unaligned places are refused
    rchk(8'h3c, 32'h0000_0000, "unmapped_data");
    chk_b("unmapped_err", 1'b1, rerr);
    rd(8'h02);
    chk_b("unaligned_err", 1'b1, rerr);
    conclude();
  end
endmodule
